// File: pkg/sps_pkg.sv
package sps_pkg;

	localparam int SEG_COUNT = 30;
	localparam int IDX_W = 5;
	localparam int SP_W = 16;
	localparam int DUR_W = 16;

	// ----------------------------------------------------------------
	// Option byte fields
	// ----------------------------------------------------------------
	localparam int OPT_HOLD_BELOW = 0;
	localparam int OPT_HOLD_ABOVE = 1;
	localparam int OPT_RATE = 2;
	localparam int OPT_NO_ADJUST = 6;
	localparam int OPT_MINUTES = 7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ = 125_000_000;
	localparam int unsigned TIME_UNIT_S = 1;
	localparam int unsigned SEC_CYCLES = CLK_FREQ_HZ * TIME_UNIT_S;
	localparam logic [5:0] SEC_PER_MIN_LAST = 6'h3B;
	localparam logic [31:0] SEC_PER_HOUR = 32'h00000E10;
	// Setpoints are held in tenths of a temperature unit.
	localparam logic [31:0] SP_SCALE = 32'h0000000A;
	localparam logic [3:0] STARTUP_READINGS = 4'h4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_RST = 5'h00;
	localparam logic [SP_W-1:0] SP_RST = 16'h0000;
	localparam logic [DUR_W-1:0] DUR_RST = 16'h0000;
	localparam logic [7:0] OPT_RST = 8'h00;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LOAD = 4'b0010,
		ST_RUN = 4'b0100,
		ST_DONE = 4'b1000
	} sps_state_t;

endpackage : sps_pkg

// File: rtl/sps_sequencer.sv
`timescale 1ns/1ns
module sps_sequencer #(
	parameter int unsigned SEC_CYCLES = sps_pkg::SEC_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic seg_wr_i,
	input wire logic [sps_pkg::IDX_W-1:0] seg_wr_index_i,
	input wire logic [sps_pkg::DUR_W-1:0] seg_wr_duration_i,
	input wire logic [sps_pkg::SP_W-1:0] seg_wr_exit_setpoint_i,
	input wire logic [7:0] seg_wr_option_i,
	input wire logic [sps_pkg::IDX_W-1:0] seg_rd_index_i,
	output logic [sps_pkg::DUR_W-1:0] seg_rd_duration_o,
	output logic [sps_pkg::SP_W-1:0] seg_rd_exit_setpoint_o,
	output logic [7:0] seg_rd_option_o,
	input wire logic [sps_pkg::IDX_W-1:0] first_segment_index_i,
	input wire logic [sps_pkg::IDX_W-1:0] stop_segment_index_i,
	input wire logic profile_run_request_i,
	input wire logic manual_hold_request_i,
	input wire logic [sps_pkg::SP_W-1:0] hold_error_band_i,
	input wire logic [sps_pkg::SP_W-1:0] hold_band_hysteresis_i,
	input wire logic [sps_pkg::SP_W-1:0] normal_setpoint_i,
	input wire logic [sps_pkg::SP_W-1:0] alternate_setpoint_i,
	input wire logic setpoint_source_select_i,
	input wire logic [sps_pkg::SP_W-1:0] setpoint_ramp_limit_i,
	input wire logic [sps_pkg::SP_W-1:0] hw_process_value_i,
	input wire logic [sps_pkg::SP_W-1:0] alternate_process_value_i,
	input wire logic process_value_source_select_i,
	input wire logic pv_sample_i,
	input wire logic manual_mode_i,
	input wire logic input_fault_i,
	output logic [sps_pkg::SP_W-1:0] working_setpoint_o,
	output logic [sps_pkg::SP_W-1:0] process_value_o,
	output logic derivative_inhibit_o,
	output logic profile_running_flag_o,
	output logic profile_finished_flag_o,
	output logic [sps_pkg::IDX_W-1:0] current_segment_index_o,
	output logic [sps_pkg::DUR_W-1:0] segment_time_left_o,
	output logic automatic_hold_flag_o,
	output logic manual_hold_flag_o
);
	import sps_pkg::*;

	if (SEC_CYCLES < 2) begin : g_bad_sec
		$error("SEC_CYCLES must be at least 2");
	end

	localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		sps_state_t st;
		logic [IDX_W-1:0] idx;
		logic first_seg;
		logic [DUR_W-1:0] remain;
		logic [31:0] cyc;
		logic [5:0] sec;
		logic [31:0] racc;
		logic signed [SP_W-1:0] sp;
		logic signed [SP_W-1:0] tgt;
		logic [7:0] opt;
		logic band_hold;
		logic force_q;
		logic done;
		logic ahold;
		logic mhold;
		logic alternate_process_value_q;
		logic [3:0] startup;
		logic signed [SP_W-1:0] pv;
		logic [DUR_W-1:0] rd_dur;
		logic [SP_W-1:0] rd_sp;
		logic [7:0] rd_opt;
	} sps_regs_t;

	sps_regs_t s_r;
	sps_regs_t s_nxt;

	// Segment storage has no reset; the host programs it before a run.
	logic [DUR_W-1:0] seg_dur [SEG_COUNT];
	logic [SP_W-1:0] seg_sp [SEG_COUNT];
	logic [7:0] seg_opt [SEG_COUNT];

	always_ff @(posedge clk_sys_i) begin
		if (seg_wr_i && (32'(seg_wr_index_i) < SEG_COUNT)) begin
			seg_dur[seg_wr_index_i] <= seg_wr_duration_i;
			seg_sp[seg_wr_index_i] <= seg_wr_exit_setpoint_i;
			seg_opt[seg_wr_index_i] <= seg_wr_option_i;
		end
	end

	// ----------------------------------------------------------------
	// Arithmetic helpers
	// ----------------------------------------------------------------
	function automatic logic [SP_W:0] sps_abs_diff(input logic signed [SP_W-1:0] a,
			input logic signed [SP_W-1:0] b);
		logic signed [SP_W:0] d;
		d = $signed({b[SP_W-1], b}) - $signed({a[SP_W-1], a});
		return d[SP_W] ? (SP_W+1)'(-d) : d;
	endfunction : sps_abs_diff

	function automatic logic signed [SP_W-1:0] sps_step_toward(
			input logic signed [SP_W-1:0] from, input logic signed [SP_W-1:0] to,
			input logic [SP_W:0] step);
		if (sps_abs_diff(from, to) <= step)
			return to;
		else if (to > from)
			return SP_W'(from + step[SP_W-1:0]);
		else
			return SP_W'(from - step[SP_W-1:0]);
	endfunction : sps_step_toward

	// Keeps the original ramp rate: time scales with the distance still to go.
	function automatic logic [DUR_W-1:0] sps_scale_time(input logic [DUR_W-1:0] t,
			input logic [SP_W:0] num, input logic [SP_W:0] den);
		logic [33:0] p;
		p = 34'(t) * 34'(num);
		if (den == '0)
			return t;
		p = p / 34'(den);
		return (p > 34'(16'hFFFF)) ? 16'hFFFF : p[DUR_W-1:0];
	endfunction : sps_scale_time

	function automatic logic signed [17:0] sps_ext(input logic signed [SP_W-1:0] v);
		return {{2{v[SP_W-1]}}, v};
	endfunction : sps_ext

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic sec_tick;
	logic unit_tick;
	logic force_hold;
	logic frozen;
	logic finished_seg;
	logic [IDX_W-1:0] idx_inc;
	logic signed [SP_W-1:0] sel_sp;
	logic signed [SP_W-1:0] cur_tgt;
	logic [7:0] cur_opt;
	logic [DUR_W-1:0] cur_dur;
	logic signed [17:0] band_lo;
	logic signed [17:0] band_hi;
	logic signed [17:0] pv_x;
	logic below_set;
	logic below_clr;
	logic above_set;
	logic above_clr;
	logic signed [SP_W:0] ramp_q;
	logic [31:0] rate_acc;
	logic [SP_W:0] rate_step;

	always_comb begin
		s_nxt = s_r;
		sec_tick = (s_r.cyc == SEC_LAST);
		s_nxt.cyc = sec_tick ? 32'h00000000 : s_r.cyc + 32'h00000001;
		cur_dur = (32'(s_r.idx) < SEG_COUNT) ? seg_dur[s_r.idx] : DUR_RST;
		cur_tgt = (32'(s_r.idx) < SEG_COUNT) ? $signed(seg_sp[s_r.idx]) : $signed(SP_RST);
		cur_opt = (32'(s_r.idx) < SEG_COUNT) ? seg_opt[s_r.idx] : OPT_RST;
		sel_sp = setpoint_source_select_i ? $signed(alternate_setpoint_i)
			: $signed(normal_setpoint_i);
		idx_inc = s_r.idx + 5'h01;
		force_hold = manual_mode_i | input_fault_i;
		finished_seg = 1'b0;

		if (32'(seg_rd_index_i) < SEG_COUNT) begin
			s_nxt.rd_dur = seg_dur[seg_rd_index_i];
			s_nxt.rd_sp = seg_sp[seg_rd_index_i];
			s_nxt.rd_opt = seg_opt[seg_rd_index_i];
		end else begin
			s_nxt.rd_dur = DUR_RST;
			s_nxt.rd_sp = SP_RST;
			s_nxt.rd_opt = OPT_RST;
		end

		// Process value source and derivative startup.
		s_nxt.alternate_process_value_q = process_value_source_select_i;
		if (process_value_source_select_i != s_r.alternate_process_value_q)
			s_nxt.startup = STARTUP_READINGS;
		else if (pv_sample_i && (s_r.startup != 4'h0))
			s_nxt.startup = s_r.startup - 4'h1;
		if (pv_sample_i)
			s_nxt.pv = process_value_source_select_i ? $signed(alternate_process_value_i)
				: $signed(hw_process_value_i);

		// Hold band around the working setpoint, hysteresis on release.
		pv_x = sps_ext(s_r.pv);
		band_lo = sps_ext(s_r.sp) - $signed({2'b00, hold_error_band_i});
		band_hi = sps_ext(s_r.sp) + $signed({2'b00, hold_error_band_i});
		below_set = pv_x < band_lo;
		below_clr = pv_x >= (band_lo + $signed({2'b00, hold_band_hysteresis_i}));
		above_set = pv_x > band_hi;
		above_clr = pv_x <= (band_hi - $signed({2'b00, hold_band_hysteresis_i}));
		unit_tick = sec_tick && (!s_r.opt[OPT_MINUTES] || (s_r.sec == SEC_PER_MIN_LAST));
		frozen = s_r.band_hold | force_hold | manual_hold_request_i;
		ramp_q = $signed({s_r.tgt[SP_W-1], s_r.tgt}) - $signed({s_r.sp[SP_W-1], s_r.sp});
		ramp_q = ramp_q / $signed({1'b0, (s_r.remain == '0) ? 16'h0001 : s_r.remain});
		rate_acc = s_r.racc + 32'(cur_dur) * SP_SCALE;
		rate_step = (SP_W+1)'(rate_acc / SEC_PER_HOUR);
		s_nxt.ahold = 1'b0;
		s_nxt.mhold = 1'b0;

		unique case (s_r.st)
			ST_IDLE: begin
				s_nxt.done = 1'b0;
				s_nxt.band_hold = 1'b0;
				if (sec_tick) begin
					if (setpoint_ramp_limit_i == '0)
						s_nxt.sp = sel_sp;
					else
						s_nxt.sp = sps_step_toward(s_r.sp, sel_sp,
							{1'b0, setpoint_ramp_limit_i});
				end
				if (profile_run_request_i) begin
					s_nxt.idx = first_segment_index_i;
					s_nxt.first_seg = 1'b1;
					s_nxt.tgt = s_r.sp;
					s_nxt.remain = DUR_RST;
					if ((first_segment_index_i >= stop_segment_index_i)
							|| (32'(first_segment_index_i) >= SEG_COUNT)) begin
						s_nxt.st = ST_DONE;
						s_nxt.done = 1'b1;
					end else begin
						s_nxt.st = ST_LOAD;
					end
				end
			end
			ST_LOAD: begin
				s_nxt.tgt = cur_tgt;
				s_nxt.opt = cur_opt;
				s_nxt.racc = 32'h00000000;
				s_nxt.sec = 6'h00;
				s_nxt.band_hold = 1'b0;
				s_nxt.st = ST_RUN;
				// Forced and manual holds show from the load cycle on, so a host
				// that ORs the hold flags of several loops never sees a gap.
				s_nxt.ahold = force_hold;
				s_nxt.mhold = manual_hold_request_i;
				if (cur_opt[OPT_RATE]) begin
					s_nxt.remain = DUR_RST;
				end else if (!s_r.first_seg && !cur_opt[OPT_NO_ADJUST]
						&& (cur_tgt != s_r.tgt)) begin
					s_nxt.remain = sps_scale_time(cur_dur, sps_abs_diff(s_r.pv, cur_tgt),
						sps_abs_diff(s_r.tgt, cur_tgt));
					s_nxt.sp = s_r.pv;
				end else begin
					s_nxt.remain = cur_dur;
				end
			end
			ST_RUN: begin
				s_nxt.force_q = force_hold;
				if (s_r.band_hold)
					s_nxt.band_hold = (s_r.opt[OPT_HOLD_BELOW] && !below_clr)
						|| (s_r.opt[OPT_HOLD_ABOVE] && !above_clr);
				else
					s_nxt.band_hold = (s_r.opt[OPT_HOLD_BELOW] && below_set)
						|| (s_r.opt[OPT_HOLD_ABOVE] && above_set);
				s_nxt.ahold = s_nxt.band_hold | force_hold;
				s_nxt.mhold = manual_hold_request_i;
				if (s_r.force_q && !force_hold) begin
					if (!s_r.opt[OPT_NO_ADJUST] && !s_r.opt[OPT_RATE]) begin
						s_nxt.remain = sps_scale_time(s_r.remain, sps_abs_diff(s_r.pv, s_r.tgt),
							sps_abs_diff(s_r.sp, s_r.tgt));
						s_nxt.sp = s_r.pv;
					end
				end else if (!frozen) begin
					if (sec_tick)
						s_nxt.sec = (s_r.sec == SEC_PER_MIN_LAST) ? 6'h00 : s_r.sec + 6'h01;
					if (s_r.opt[OPT_RATE]) begin
						if (s_r.sp == s_r.tgt) begin
							finished_seg = 1'b1;
						end else if (sec_tick) begin
							// Rate is read live so a rewrite takes hold at once.
							s_nxt.racc = rate_acc % SEC_PER_HOUR;
							s_nxt.sp = sps_step_toward(s_r.sp, s_r.tgt, rate_step);
						end
					end else if (s_r.remain == '0) begin
						s_nxt.sp = s_r.tgt;
						finished_seg = 1'b1;
					end else if (unit_tick) begin
						s_nxt.sp = SP_W'(s_r.sp + ramp_q);
						s_nxt.remain = s_r.remain - 16'h0001;
					end
				end
				if (finished_seg) begin
					s_nxt.first_seg = 1'b0;
					s_nxt.ahold = 1'b0;
					s_nxt.mhold = 1'b0;
					if ((idx_inc >= stop_segment_index_i) || (32'(idx_inc) >= SEG_COUNT)) begin
						s_nxt.st = ST_DONE;
						s_nxt.done = 1'b1;
					end else begin
						s_nxt.idx = idx_inc;
						s_nxt.st = ST_LOAD;
					end
				end
			end
			ST_DONE: begin
				// The last exit value stays put until the request drops.
				s_nxt.remain = DUR_RST;
			end
		endcase

		// Dropping the request wins over everything and skips the ramp limit.
		if (!profile_run_request_i && (s_r.st != ST_IDLE)) begin
			s_nxt.st = ST_IDLE;
			s_nxt.sp = sel_sp;
			s_nxt.done = 1'b0;
			s_nxt.ahold = 1'b0;
			s_nxt.mhold = 1'b0;
			s_nxt.band_hold = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= '{st: ST_IDLE, idx: IDX_RST, first_seg: 1'b0, remain: DUR_RST,
				cyc: 32'h00000000, sec: 6'h00, racc: 32'h00000000, sp: SP_RST,
				tgt: SP_RST, opt: OPT_RST, band_hold: 1'b0, force_q: 1'b0,
				done: 1'b0, ahold: 1'b0, mhold: 1'b0, alternate_process_value_q: 1'b0, startup: 4'h0,
				pv: SP_RST, rd_dur: DUR_RST, rd_sp: SP_RST, rd_opt: OPT_RST};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign working_setpoint_o = s_r.sp;
	assign process_value_o = s_r.pv;
	assign derivative_inhibit_o = (s_r.startup != 4'h0);
	assign profile_running_flag_o = (s_r.st != ST_IDLE);
	assign profile_finished_flag_o = s_r.done;
	assign current_segment_index_o = s_r.idx;
	assign segment_time_left_o = s_r.remain;
	assign automatic_hold_flag_o = s_r.ahold;
	assign manual_hold_flag_o = s_r.mhold;
	assign seg_rd_duration_o = s_r.rd_dur;
	assign seg_rd_exit_setpoint_o = s_r.rd_sp;
	assign seg_rd_option_o = s_r.rd_opt;

endmodule : sps_sequencer

// File: tb/sps_sequencer_sva.sv
`timescale 1ns/1ns
module sps_sequencer_chk (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic profile_run_request_i,
	input wire logic manual_hold_request_i,
	input wire logic manual_mode_i,
	input wire logic input_fault_i,
	input wire logic setpoint_source_select_i,
	input wire logic process_value_source_select_i,
	input wire logic pv_sample_i,
	input wire logic [sps_pkg::IDX_W-1:0] first_segment_index_i,
	input wire logic [sps_pkg::IDX_W-1:0] stop_segment_index_i,
	input wire logic [sps_pkg::IDX_W-1:0] seg_rd_index_i,
	input wire logic [sps_pkg::SP_W-1:0] normal_setpoint_i,
	input wire logic [sps_pkg::SP_W-1:0] alternate_setpoint_i,
	input wire logic [sps_pkg::SP_W-1:0] hw_process_value_i,
	input wire logic [sps_pkg::SP_W-1:0] working_setpoint_o,
	input wire logic [sps_pkg::SP_W-1:0] process_value_o,
	input wire logic [sps_pkg::DUR_W-1:0] segment_time_left_o,
	input wire logic [sps_pkg::DUR_W-1:0] seg_rd_duration_o,
	input wire logic derivative_inhibit_o,
	input wire logic profile_running_flag_o,
	input wire logic profile_finished_flag_o,
	input wire logic [sps_pkg::IDX_W-1:0] current_segment_index_o,
	input wire logic automatic_hold_flag_o,
	input wire logic manual_hold_flag_o
);
	import sps_pkg::*;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	a_run_ack: assert property (!profile_running_flag_o && profile_run_request_i
		|=> profile_running_flag_o) else $error("run request not acknowledged");
	a_start_index: assert property (!profile_running_flag_o && profile_run_request_i
		&& first_segment_index_i < stop_segment_index_i && first_segment_index_i < 5'h1E
		|=> current_segment_index_o == $past(first_segment_index_i)) else $error("bad first index");
	a_drop_idle: assert property (!profile_run_request_i |=>
		!profile_running_flag_o && !profile_finished_flag_o) else $error("flags kept after stop");
	a_drop_setpoint: assert property (profile_running_flag_o && !profile_run_request_i
		|=> working_setpoint_o == ($past(setpoint_source_select_i) ? $past(alternate_setpoint_i)
		: $past(normal_setpoint_i))) else $error("setpoint did not jump on stop");
	a_hold_freeze: assert property (profile_run_request_i && manual_hold_request_i
		&& manual_hold_flag_o && $past(profile_running_flag_o)
		|=> $stable(segment_time_left_o)) else $error("time left moved during hold");
	a_fault_hold: assert property ((input_fault_i || manual_mode_i) && profile_run_request_i
		&& profile_running_flag_o && !profile_finished_flag_o |=> automatic_hold_flag_o)
		else $error("forced hold not flagged");
	a_done_hold: assert property (profile_finished_flag_o && profile_run_request_i
		|=> !profile_run_request_i || $stable(working_setpoint_o)) else $error("final setpoint moved");
	a_pv_capture: assert property (pv_sample_i && !process_value_source_select_i
		|=> process_value_o == $past(hw_process_value_i)) else $error("process value not captured");
	a_alt_startup: assert property ($changed(process_value_source_select_i)
		|-> ##[1:2] derivative_inhibit_o) else $error("no startup after source change");
	a_rd_range: assert property (seg_rd_index_i > 5'h1D
		|=> seg_rd_duration_o == 16'h0000) else $error("readback beyond range not zero");
	c_done: cover property (profile_finished_flag_o && profile_run_request_i);
	c_auto: cover property (automatic_hold_flag_o && profile_running_flag_o);
	c_manual: cover property (manual_hold_flag_o && profile_running_flag_o);
endmodule : sps_sequencer_chk

// File: tb/sps_master_model.sv
`timescale 1ns/1ns
module sps_master_model (
	input wire logic clk_i,
	output logic seg_wr_o,
	output logic [sps_pkg::IDX_W-1:0] seg_idx_o,
	output logic [sps_pkg::DUR_W-1:0] seg_dur_o,
	output logic [sps_pkg::SP_W-1:0] seg_sp_o,
	output logic [7:0] seg_opt_o,
	output logic [sps_pkg::IDX_W-1:0] first_o,
	output logic [sps_pkg::IDX_W-1:0] stop_o,
	output logic run_o
);
	import sps_pkg::*;
	initial begin
		{seg_wr_o, seg_idx_o, seg_dur_o, seg_sp_o, seg_opt_o, first_o, stop_o, run_o} = '0;
	end
	task automatic wr_seg(input logic [IDX_W-1:0] i, input logic [DUR_W-1:0] d,
		input logic [SP_W-1:0] s, input logic [7:0] o);
		@(negedge clk_i);
		{seg_wr_o, seg_idx_o, seg_dur_o, seg_sp_o, seg_opt_o} = {1'b1, i, d, s, o};
		@(negedge clk_i);
		seg_wr_o = 1'b0;
		// Stale data is inverted so a late capture cannot pass by luck.
		{seg_dur_o, seg_sp_o, seg_opt_o} = ~{d, s, o};
	endtask : wr_seg
	task automatic start(input logic [IDX_W-1:0] f, input logic [IDX_W-1:0] s);
		@(negedge clk_i);
		first_o = f;
		@(negedge clk_i);
		stop_o = s;
		@(negedge clk_i);
		run_o = 1'b1;
	endtask : start
	task automatic stop_run();
		@(negedge clk_i);
		run_o = 1'b0;
	endtask : stop_run
endmodule : sps_master_model

// File: tb/sps_sequencer_tb.sv
`timescale 1ns/1ns
module sps_sequencer_tb;
	import sps_pkg::*;
	typedef struct {int due; int w; logic [15:0] e;} sps_note_t;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic manual_hold_request_i = 1'b0;
	logic setpoint_source_select_i = 1'b0;
	logic process_value_source_select_i = 1'b0;
	logic pv_sample_i = 1'b0;
	logic manual_mode_i = 1'b0;
	logic input_fault_i = 1'b0;
	logic [IDX_W-1:0] seg_rd_index_i = 5'h00;
	logic [SP_W-1:0] hold_error_band_i = 16'h0010;
	logic [SP_W-1:0] hold_band_hysteresis_i = 16'h0004;
	logic [SP_W-1:0] normal_setpoint_i = 16'h0100;
	logic [SP_W-1:0] setpoint_ramp_limit_i = 16'h0000;
	logic [SP_W-1:0] alternate_setpoint_i = 16'h0000;
	logic [SP_W-1:0] hw_process_value_i = 16'h0000;
	logic [SP_W-1:0] alternate_process_value_i = 16'h0000;
	wire logic seg_wr_i, profile_run_request_i, derivative_inhibit_o, profile_running_flag_o;
	wire logic profile_finished_flag_o, automatic_hold_flag_o, manual_hold_flag_o;
	wire logic [IDX_W-1:0] seg_wr_index_i, first_segment_index_i, stop_segment_index_i;
	wire logic [IDX_W-1:0] current_segment_index_o;
	wire logic [DUR_W-1:0] seg_wr_duration_i, seg_rd_duration_o, segment_time_left_o;
	wire logic [SP_W-1:0] seg_wr_exit_setpoint_i, seg_rd_exit_setpoint_o;
	wire logic [SP_W-1:0] working_setpoint_o, process_value_o;
	wire logic [7:0] seg_wr_option_i, seg_rd_option_o;
	int cyc = 0;
	int seed = 64;
	int failures = 0;
	int cmp_count = 0;
	sps_note_t q[$];
	logic [63:0] mem [5];
	logic [7:0] b_opt [3] = '{8'h01, 8'h02, 8'h03};
	logic [15:0] b_pv [3] = '{16'h00EF, 16'h0111, 16'h0100};
	// A soak target keeps the setpoint still, so the pv lands one count past the upper band edge.
	logic [15:0] b_tgt [3] = '{16'h0300, 16'h0100, 16'h0100};
	always #4 clk_sys_i = ~clk_sys_i;
	sps_sequencer #(.SEC_CYCLES(10)) sps_sequencer_inst (.*);
	sps_master_model sps_master_model_inst (.clk_i(clk_sys_i), .seg_wr_o(seg_wr_i),
		.seg_idx_o(seg_wr_index_i), .seg_dur_o(seg_wr_duration_i), .seg_sp_o(seg_wr_exit_setpoint_i),
		.seg_opt_o(seg_wr_option_i), .first_o(first_segment_index_i),
		.stop_o(stop_segment_index_i), .run_o(profile_run_request_i));
	function automatic logic [15:0] obs(input int w);
		case (w)
			0: obs = working_setpoint_o;
			1: obs = segment_time_left_o;
			2: obs = {15'h0000, profile_running_flag_o};
			3: obs = {11'h000, current_segment_index_o};
			4: obs = {15'h0000, profile_finished_flag_o};
			5: obs = seg_rd_duration_o;
			6: obs = seg_rd_exit_setpoint_o;
			7: obs = {8'h00, seg_rd_option_o};
			8: obs = {15'h0000, manual_hold_flag_o};
			9: obs = {15'h0000, automatic_hold_flag_o};
			10: obs = process_value_o;
			default: obs = {15'h0000, derivative_inhibit_o};
		endcase
	endfunction : obs
	task automatic note(input int w, input int d, input logic [15:0] e);
		q.push_back('{cyc + d, w, e});
	endtask : note
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done();
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	task automatic wait_for(input int w, input logic [15:0] v);
		int n = 0;
		while (obs(w) !== v && n < 2000) begin
			@(negedge clk_sys_i);
			n++;
		end
		if (n == 2000) begin
			failures++;
			test_done();
		end
	endtask : wait_for
	task automatic pv_take(input logic [15:0] v);
		@(negedge clk_sys_i);
		hw_process_value_i = v;
		pv_sample_i = 1'b1;
		note(10, 1, v);
		@(negedge clk_sys_i);
		pv_sample_i = 1'b0;
	endtask : pv_take
	// ----------------------------------------------------------------
	// Result watcher and run limit
	// ----------------------------------------------------------------
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			test_done();
		end
	end
	always @(negedge clk_sys_i) begin
		for (int i = q.size() - 1; i >= 0; i--) begin
			if (q[i].due == cyc) begin
				check(obs(q[i].w), q[i].e);
				q.delete(i);
			end
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rstn_i = 1'b1;
		for (int i = 0; i < 5; i++) begin
			mem[i] = {$random(seed), $random(seed)};
			sps_master_model_inst.wr_seg(5'(i < 4 ? 10 + i : 30), mem[i][39:24], mem[i][23:8],
				mem[i][7:0]);
		end
		for (int i = 0; i < 5; i++) begin
			@(negedge clk_sys_i);
			seg_rd_index_i = 5'(i < 4 ? 10 + i : 30);
			note(5, 1, i < 4 ? mem[i][39:24] : 16'h0000);
			note(6, 1, i < 4 ? mem[i][23:8] : 16'h0000);
			note(7, 1, i < 4 ? {8'h00, mem[i][7:0]} : 16'h0000);
		end
		sps_master_model_inst.wr_seg(5'h00, 16'h0003, 16'h0200, 8'h40);
		sps_master_model_inst.wr_seg(5'h01, 16'h0002, 16'h0200, 8'h40);
		sps_master_model_inst.wr_seg(5'h02, 16'h0005, 16'h0300, 8'h00);
		sps_master_model_inst.wr_seg(5'h04, 16'h0002, 16'h0300, 8'hC0);
		sps_master_model_inst.wr_seg(5'h05, 16'h8CA0, 16'h0300, 8'h04);
		pv_take(16'h0200);
		sps_master_model_inst.start(5'h00, 5'h02);
		note(2, 1, 16'h0001);
		note(3, 1, 16'h0000);
		note(1, 2, 16'h0003);
		wait_for(3, 16'h0001);
		note(0, 2, 16'h0200);
		wait_for(4, 16'h0001);
		note(0, 5, 16'h0200);
		repeat (5) @(negedge clk_sys_i);
		setpoint_source_select_i = 1'b1;
		alternate_setpoint_i = 16'($random(seed));
		sps_master_model_inst.stop_run();
		note(2, 1, 16'h0000);
		note(0, 1, alternate_setpoint_i);
		@(negedge clk_sys_i);
		setpoint_source_select_i = 1'b0;
		manual_hold_request_i = 1'b1;
		pv_take(16'h0000);
		sps_master_model_inst.start(5'h02, 5'h03);
		note(1, 2, 16'h0005);
		note(8, 3, 16'h0001);
		note(1, 40, 16'h0005);
		repeat (41) @(negedge clk_sys_i);
		manual_hold_request_i = 1'b0;
		input_fault_i = 1'b1;
		note(8, 2, 16'h0000);
		note(9, 2, 16'h0001);
		repeat (3) @(negedge clk_sys_i);
		input_fault_i = 1'b0;
		manual_mode_i = 1'b1;
		note(9, 2, 16'h0001);
		repeat (3) @(negedge clk_sys_i);
		manual_mode_i = 1'b0;
		sps_master_model_inst.stop_run();
		for (int k = 0; k < 3; k++) begin
			sps_master_model_inst.wr_seg(5'h03, 16'h0005, b_tgt[k], b_opt[k]);
			pv_take(b_pv[k]);
			sps_master_model_inst.start(5'h03, 5'h04);
			note(9, 6, {15'h0000, k < 2});
			note(9, 20, {15'h0000, k < 2});
			repeat (21) @(negedge clk_sys_i);
			manual_hold_request_i = automatic_hold_flag_o;
			note(8, 1, {15'h0000, k < 2});
			sps_master_model_inst.stop_run();
			manual_hold_request_i = 1'b0;
		end
		sps_master_model_inst.start(5'h04, 5'h05);
		note(1, 100, 16'h0002);
		repeat (101) @(negedge clk_sys_i);
		sps_master_model_inst.stop_run();
		sps_master_model_inst.start(5'h05, 5'h06);
		wait_for(4, 16'h0001);
		note(0, 1, 16'h0300);
		sps_master_model_inst.stop_run();
		sps_master_model_inst.start(5'h06, 5'h06);
		note(4, 3, 16'h0001);
		repeat (3) @(negedge clk_sys_i);
		sps_master_model_inst.stop_run();
		process_value_source_select_i = 1'b1;
		note(11, 2, 16'h0001);
		alternate_process_value_i = 16'($random(seed));
		@(negedge clk_sys_i);
		pv_sample_i = 1'b1;
		note(10, 1, alternate_process_value_i);
		@(negedge clk_sys_i);
		pv_sample_i = 1'b0;
		repeat (5) @(negedge clk_sys_i);
		test_done();
	end
endmodule : sps_sequencer_tb
bind sps_sequencer sps_sequencer_chk sps_sequencer_chk_inst (.*);
